/* rtl/gp_pkg.sv */
// package: register map, reset values and widths of the port block
package gp_pkg;
    localparam int          ADR_W   = 8;
    localparam int          DAT_W   = 32;
    localparam int          IRQ_N   = 7;
    localparam int          ST_W    = 8;
    localparam int          KEY_BIT = 7;
    // register byte offsets
    localparam logic [7:0]  A_P2_DAT  = 8'h00;
    localparam logic [7:0]  A_P2_MODE = 8'h04;
    localparam logic [7:0]  A_P3_DAT  = 8'h08;
    localparam logic [7:0]  A_P3_DIR  = 8'h0c;
    localparam logic [7:0]  A_P3_PU   = 8'h10;
    localparam logic [7:0]  A_P3_MODE = 8'h14;
    localparam logic [7:0]  A_P4_DAT  = 8'h18;
    localparam logic [7:0]  A_P4_DIR  = 8'h1c;
    localparam logic [7:0]  A_P4_PU   = 8'h20;
    localparam logic [7:0]  A_P5_DAT  = 8'h24;
    localparam logic [7:0]  A_P5_DIR  = 8'h28;
    localparam logic [7:0]  A_P5_PU   = 8'h2c;
    localparam logic [7:0]  A_P6_DAT  = 8'h30;
    localparam logic [7:0]  A_P6_DIR  = 8'h34;
    localparam logic [7:0]  A_P7_DAT  = 8'h38;
    localparam logic [7:0]  A_P7_DIR  = 8'h3c;
    localparam logic [7:0]  A_P7_PU   = 8'h40;
    localparam logic [7:0]  A_P7_MODE = 8'h44;
    localparam logic [7:0]  A_P12_DAT = 8'h48;
    localparam logic [7:0]  A_P12_DIR = 8'h4c;
    localparam logic [7:0]  A_P12_PU  = 8'h50;
    localparam logic [7:0]  A_P12_MOD = 8'h54;
    localparam logic [7:0]  A_P13_DAT = 8'h58;
    localparam logic [7:0]  A_P14_DAT = 8'h5c;
    localparam logic [7:0]  A_P14_DIR = 8'h60;
    localparam logic [7:0]  A_P14_PU  = 8'h64;
    localparam logic [7:0]  A_P14_MOD = 8'h68;
    localparam logic [7:0]  A_EDGE_R  = 8'h6c;
    localparam logic [7:0]  A_EDGE_F  = 8'h70;
    localparam logic [7:0]  A_IRQ_ST  = 8'h74;
    localparam logic [7:0]  A_IRQ_MSK = 8'h78;
    // reset values: direction all input, everything else clear
    localparam logic [7:0]  DIR_RST   = 8'hff;
    localparam logic [7:0]  CFG_RST   = 8'h00;
endpackage

/* rtl/gp_port_ctrl.sv */
// module: port pin control with wishbone registers and edge interrupts
//
// Operation
// - Port 2 is eight input-only pins that become analog channels in mode.
// - Each multi-use pin picks port or alternate function on its own.
// - Port 3 is four I/O pins with per-bit direction register.
// - Every I/O port but port 6 has a per-pin pull-up enable register.
// - External interrupt pins detect rising, falling or both edges.
// - Port 3 in mode gives four interrupt inputs, timer clock and output.
// - Ports 4 and 5 are four I/O pins each with direction and pull-up.
// - Port 6 is four open-drain I/O pins with no pull-up control.
// - Port 7 is eight I/O pins that act as key interrupts in mode.
// - Port 12 is one I/O pin that is an edge interrupt input in mode.
// - Port 13 is one output-only pin driven from its latch.
// - Port 14 is two I/O pins giving interrupts, clock and buzzer out.
// - A low level on the system reset pin resets the block.
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module gp_port_ctrl (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        sys_reset_n_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    input  wire logic [7:0]  p2_pin_i,
    output logic      [7:0]  analog_input_channels_o,
    input  wire logic [3:0]  p3_pin_i,
    output logic      [3:0]  p3_out_o,
    output logic      [3:0]  p3_oe_o,
    output logic      [3:0]  p3_pu_o,
    input  wire logic        timer_b_output_i,
    output logic             timer_b_count_clock_in_o,
    input  wire logic [3:0]  p4_pin_i,
    output logic      [3:0]  p4_out_o,
    output logic      [3:0]  p4_oe_o,
    output logic      [3:0]  p4_pu_o,
    input  wire logic [3:0]  p5_pin_i,
    output logic      [3:0]  p5_out_o,
    output logic      [3:0]  p5_oe_o,
    output logic      [3:0]  p5_pu_o,
    input  wire logic [3:0]  p6_pin_i,
    output logic      [3:0]  p6_out_o,
    output logic      [3:0]  p6_oe_o,
    input  wire logic [7:0]  p7_pin_i,
    output logic      [7:0]  p7_out_o,
    output logic      [7:0]  p7_oe_o,
    output logic      [7:0]  p7_pu_o,
    input  wire logic        p12_pin_i,
    output logic             p12_out_o,
    output logic             p12_oe_o,
    output logic             p12_pu_o,
    output logic             p13_out_o,
    input  wire logic [1:0]  p14_pin_i,
    output logic      [1:0]  p14_out_o,
    output logic      [1:0]  p14_oe_o,
    output logic      [1:0]  p14_pu_o,
    input  wire logic        clock_output_src_i,
    input  wire logic        buzzer_output_src_i
);
    logic        rst;
    logic        ack_r;
    logic        acc;
    logic        wr;
    logic        rd;
    logic [7:0]  wd;
    logic [31:0] rdat;
    logic [7:0]  p2_mode_r;
    logic [3:0]  p3_lat_r, p3_dir_r, p3_pu_r, p3_mode_r;
    logic [3:0]  p4_lat_r, p4_dir_r, p4_pu_r;
    logic [3:0]  p5_lat_r, p5_dir_r, p5_pu_r;
    logic [3:0]  p6_lat_r, p6_dir_r;
    logic [7:0]  p7_lat_r, p7_dir_r, p7_pu_r, p7_mode_r;
    logic        p12_lat_r, p12_dir_r, p12_pu_r, p12_mode_r;
    logic        p13_lat_r;
    logic [1:0]  p14_lat_r, p14_dir_r, p14_pu_r, p14_mode_r;
    logic [6:0]  edge_rise_r, edge_fall_r;
    logic [7:0]  irq_st_r, irq_st_nxt, irq_msk_r;
    logic [6:0]  src, src_en, src_prev_r, ev;
    logic [7:0]  p7_prev_r;
    logic        key_ev;

    assign rst = rst_i | ~sys_reset_n_i;
    assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr  = acc & wb_we_i & wb_sel_i[0];
    assign rd  = acc & ~wb_we_i;
    assign wd  = wb_dat_i[7:0];

    // bus handshake: one wait state, ack for one cycle
    always_ff @(posedge clk_i) begin
        if (rst) begin
            ack_r    <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_r    <= acc;
            wb_dat_o <= rd ? rdat : 32'h0;
        end
    end
    assign wb_ack_o = ack_r;

    // read mux, unmapped reads as zero
    always_comb begin
        rdat = 32'h0;
        if (wb_adr_i == gp_pkg::A_P2_DAT)
            rdat[7:0] = p2_pin_i & ~p2_mode_r;
        else if (wb_adr_i == gp_pkg::A_P2_MODE)
            rdat[7:0] = p2_mode_r;
        else if (wb_adr_i == gp_pkg::A_P3_DAT)
            rdat[3:0] = (p3_dir_r & p3_pin_i) | (~p3_dir_r & p3_lat_r);
        else if (wb_adr_i == gp_pkg::A_P3_DIR)
            rdat[3:0] = p3_dir_r;
        else if (wb_adr_i == gp_pkg::A_P3_PU)
            rdat[3:0] = p3_pu_r;
        else if (wb_adr_i == gp_pkg::A_P3_MODE)
            rdat[3:0] = p3_mode_r;
        else if (wb_adr_i == gp_pkg::A_P4_DAT)
            rdat[3:0] = (p4_dir_r & p4_pin_i) | (~p4_dir_r & p4_lat_r);
        else if (wb_adr_i == gp_pkg::A_P4_DIR)
            rdat[3:0] = p4_dir_r;
        else if (wb_adr_i == gp_pkg::A_P4_PU)
            rdat[3:0] = p4_pu_r;
        else if (wb_adr_i == gp_pkg::A_P5_DAT)
            rdat[3:0] = (p5_dir_r & p5_pin_i) | (~p5_dir_r & p5_lat_r);
        else if (wb_adr_i == gp_pkg::A_P5_DIR)
            rdat[3:0] = p5_dir_r;
        else if (wb_adr_i == gp_pkg::A_P5_PU)
            rdat[3:0] = p5_pu_r;
        else if (wb_adr_i == gp_pkg::A_P6_DAT)
            rdat[3:0] = (p6_dir_r & p6_pin_i) | (~p6_dir_r & p6_lat_r);
        else if (wb_adr_i == gp_pkg::A_P6_DIR)
            rdat[3:0] = p6_dir_r;
        else if (wb_adr_i == gp_pkg::A_P7_DAT)
            rdat[7:0] = (p7_dir_r & p7_pin_i) | (~p7_dir_r & p7_lat_r);
        else if (wb_adr_i == gp_pkg::A_P7_DIR)
            rdat[7:0] = p7_dir_r;
        else if (wb_adr_i == gp_pkg::A_P7_PU)
            rdat[7:0] = p7_pu_r;
        else if (wb_adr_i == gp_pkg::A_P7_MODE)
            rdat[7:0] = p7_mode_r;
        else if (wb_adr_i == gp_pkg::A_P12_DAT)
            rdat[0] = p12_dir_r ? p12_pin_i : p12_lat_r;
        else if (wb_adr_i == gp_pkg::A_P12_DIR)
            rdat[0] = p12_dir_r;
        else if (wb_adr_i == gp_pkg::A_P12_PU)
            rdat[0] = p12_pu_r;
        else if (wb_adr_i == gp_pkg::A_P12_MOD)
            rdat[0] = p12_mode_r;
        else if (wb_adr_i == gp_pkg::A_P13_DAT)
            rdat[0] = p13_lat_r;
        else if (wb_adr_i == gp_pkg::A_P14_DAT)
            rdat[1:0] = (p14_dir_r & p14_pin_i) | (~p14_dir_r & p14_lat_r);
        else if (wb_adr_i == gp_pkg::A_P14_DIR)
            rdat[1:0] = p14_dir_r;
        else if (wb_adr_i == gp_pkg::A_P14_PU)
            rdat[1:0] = p14_pu_r;
        else if (wb_adr_i == gp_pkg::A_P14_MOD)
            rdat[1:0] = p14_mode_r;
        else if (wb_adr_i == gp_pkg::A_EDGE_R)
            rdat[6:0] = edge_rise_r;
        else if (wb_adr_i == gp_pkg::A_EDGE_F)
            rdat[6:0] = edge_fall_r;
        else if (wb_adr_i == gp_pkg::A_IRQ_ST)
            rdat[7:0] = irq_st_r;
        else if (wb_adr_i == gp_pkg::A_IRQ_MSK)
            rdat[7:0] = irq_msk_r;
    end

    // configuration and latch registers
    always_ff @(posedge clk_i) begin
        if (rst) begin
            p2_mode_r  <= gp_pkg::CFG_RST;
            p3_lat_r   <= gp_pkg::CFG_RST[3:0];
            p3_dir_r   <= gp_pkg::DIR_RST[3:0];
            p3_pu_r    <= gp_pkg::CFG_RST[3:0];
            p3_mode_r  <= gp_pkg::CFG_RST[3:0];
            p4_lat_r   <= gp_pkg::CFG_RST[3:0];
            p4_dir_r   <= gp_pkg::DIR_RST[3:0];
            p4_pu_r    <= gp_pkg::CFG_RST[3:0];
            p5_lat_r   <= gp_pkg::CFG_RST[3:0];
            p5_dir_r   <= gp_pkg::DIR_RST[3:0];
            p5_pu_r    <= gp_pkg::CFG_RST[3:0];
            p6_lat_r   <= gp_pkg::CFG_RST[3:0];
            p6_dir_r   <= gp_pkg::DIR_RST[3:0];
            p7_lat_r   <= gp_pkg::CFG_RST;
            p7_dir_r   <= gp_pkg::DIR_RST;
            p7_pu_r    <= gp_pkg::CFG_RST;
            p7_mode_r  <= gp_pkg::CFG_RST;
            p12_lat_r  <= gp_pkg::CFG_RST[0];
            p12_dir_r  <= gp_pkg::DIR_RST[0];
            p12_pu_r   <= gp_pkg::CFG_RST[0];
            p12_mode_r <= gp_pkg::CFG_RST[0];
            p13_lat_r  <= gp_pkg::CFG_RST[0];
            p14_lat_r  <= gp_pkg::CFG_RST[1:0];
            p14_dir_r  <= gp_pkg::DIR_RST[1:0];
            p14_pu_r   <= gp_pkg::CFG_RST[1:0];
            p14_mode_r <= gp_pkg::CFG_RST[1:0];
            edge_rise_r <= gp_pkg::CFG_RST[6:0];
            edge_fall_r <= gp_pkg::CFG_RST[6:0];
            irq_msk_r  <= gp_pkg::CFG_RST;
        end else if (wr) begin
            if (wb_adr_i == gp_pkg::A_P2_MODE)
                p2_mode_r <= wd;
            else if (wb_adr_i == gp_pkg::A_P3_DAT)
                p3_lat_r <= wd[3:0];
            else if (wb_adr_i == gp_pkg::A_P3_DIR)
                p3_dir_r <= wd[3:0];
            else if (wb_adr_i == gp_pkg::A_P3_PU)
                p3_pu_r <= wd[3:0];
            else if (wb_adr_i == gp_pkg::A_P3_MODE)
                p3_mode_r <= wd[3:0];
            else if (wb_adr_i == gp_pkg::A_P4_DAT)
                p4_lat_r <= wd[3:0];
            else if (wb_adr_i == gp_pkg::A_P4_DIR)
                p4_dir_r <= wd[3:0];
            else if (wb_adr_i == gp_pkg::A_P4_PU)
                p4_pu_r <= wd[3:0];
            else if (wb_adr_i == gp_pkg::A_P5_DAT)
                p5_lat_r <= wd[3:0];
            else if (wb_adr_i == gp_pkg::A_P5_DIR)
                p5_dir_r <= wd[3:0];
            else if (wb_adr_i == gp_pkg::A_P5_PU)
                p5_pu_r <= wd[3:0];
            else if (wb_adr_i == gp_pkg::A_P6_DAT)
                p6_lat_r <= wd[3:0];
            else if (wb_adr_i == gp_pkg::A_P6_DIR)
                p6_dir_r <= wd[3:0];
            else if (wb_adr_i == gp_pkg::A_P7_DAT)
                p7_lat_r <= wd;
            else if (wb_adr_i == gp_pkg::A_P7_DIR)
                p7_dir_r <= wd;
            else if (wb_adr_i == gp_pkg::A_P7_PU)
                p7_pu_r <= wd;
            else if (wb_adr_i == gp_pkg::A_P7_MODE)
                p7_mode_r <= wd;
            else if (wb_adr_i == gp_pkg::A_P12_DAT)
                p12_lat_r <= wd[0];
            else if (wb_adr_i == gp_pkg::A_P12_DIR)
                p12_dir_r <= wd[0];
            else if (wb_adr_i == gp_pkg::A_P12_PU)
                p12_pu_r <= wd[0];
            else if (wb_adr_i == gp_pkg::A_P12_MOD)
                p12_mode_r <= wd[0];
            else if (wb_adr_i == gp_pkg::A_P13_DAT)
                p13_lat_r <= wd[0];
            else if (wb_adr_i == gp_pkg::A_P14_DAT)
                p14_lat_r <= wd[1:0];
            else if (wb_adr_i == gp_pkg::A_P14_DIR)
                p14_dir_r <= wd[1:0];
            else if (wb_adr_i == gp_pkg::A_P14_PU)
                p14_pu_r <= wd[1:0];
            else if (wb_adr_i == gp_pkg::A_P14_MOD)
                p14_mode_r <= wd[1:0];
            else if (wb_adr_i == gp_pkg::A_EDGE_R)
                edge_rise_r <= wd[6:0];
            else if (wb_adr_i == gp_pkg::A_EDGE_F)
                edge_fall_r <= wd[6:0];
            else if (wb_adr_i == gp_pkg::A_IRQ_MSK)
                irq_msk_r <= wd;
        end
    end

    // pin drivers, dir bit 1 means input
    always_ff @(posedge clk_i) begin
        if (rst) begin
            p3_out_o  <= 4'h0;
            p3_oe_o   <= 4'h0;
            p4_out_o  <= 4'h0;
            p4_oe_o   <= 4'h0;
            p5_out_o  <= 4'h0;
            p5_oe_o   <= 4'h0;
            p6_out_o  <= 4'h0;
            p6_oe_o   <= 4'h0;
            p7_out_o  <= 8'h00;
            p7_oe_o   <= 8'h00;
            p12_out_o <= 1'b0;
            p12_oe_o  <= 1'b0;
            p13_out_o <= 1'b0;
            p14_out_o <= 2'h0;
            p14_oe_o  <= 2'h0;
            analog_input_channels_o  <= 8'h00;
            timer_b_count_clock_in_o <= 1'b0;
        end else begin
            p3_out_o  <= {p3_mode_r[3] ? timer_b_output_i : p3_lat_r[3],
                          p3_lat_r[2:0]};
            p3_oe_o   <= ~p3_dir_r;
            p4_out_o  <= p4_lat_r;
            p4_oe_o   <= ~p4_dir_r;
            p5_out_o  <= p5_lat_r;
            p5_oe_o   <= ~p5_dir_r;
            p6_out_o  <= 4'h0;
            p6_oe_o   <= ~p6_dir_r & ~p6_lat_r;
            p7_out_o  <= p7_lat_r;
            p7_oe_o   <= ~p7_dir_r;
            p12_out_o <= p12_lat_r;
            p12_oe_o  <= ~p12_dir_r;
            p13_out_o <= p13_lat_r;
            p14_out_o <= {p14_mode_r[1] ? buzzer_output_src_i : p14_lat_r[1],
                          p14_mode_r[0] ? clock_output_src_i : p14_lat_r[0]};
            p14_oe_o  <= ~p14_dir_r;
            analog_input_channels_o  <= p2_mode_r;
            timer_b_count_clock_in_o <= p3_mode_r[3] & p3_pin_i[3];
        end
    end
    assign p3_pu_o  = p3_pu_r;
    assign p4_pu_o  = p4_pu_r;
    assign p5_pu_o  = p5_pu_r;
    assign p7_pu_o  = p7_pu_r;
    assign p12_pu_o = p12_pu_r;
    assign p14_pu_o = p14_pu_r;

    // interrupt sources: 0 port 12, 1..4 port 3, 5..6 port 14
    assign src    = {p14_pin_i, p3_pin_i, p12_pin_i};
    assign src_en = {p14_mode_r, p3_mode_r, p12_mode_r};

    genvar gi;
    generate
        for (gi = 0; gi < gp_pkg::IRQ_N; gi++) begin : g_edge
            assign ev[gi] = src_en[gi] &
                ((edge_rise_r[gi] & src[gi] & ~src_prev_r[gi]) |
                 (edge_fall_r[gi] & ~src[gi] & src_prev_r[gi]));
        end
    endgenerate
    assign key_ev = |(p7_mode_r & ~p7_pin_i & p7_prev_r);

    always_ff @(posedge clk_i) begin
        if (rst) begin
            src_prev_r <= 7'h00;
            p7_prev_r  <= 8'h00;
        end else begin
            src_prev_r <= src;
            p7_prev_r  <= p7_pin_i;
        end
    end

    // sticky status, read clears, a new event wins
    always_comb begin
        irq_st_nxt = irq_st_r;
        if (rd && wb_adr_i == gp_pkg::A_IRQ_ST)
            irq_st_nxt = 8'h00;
        irq_st_nxt = irq_st_nxt | {key_ev, ev};
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            irq_st_r <= 8'h00;
            irq_o    <= 1'b0;
        end else begin
            irq_st_r <= irq_st_nxt;
            irq_o    <= |(irq_st_nxt & irq_msk_r);
        end
    end

    AST_P2_READ: assert property (@(posedge clk_i) disable iff (rst)
        rd && wb_adr_i == gp_pkg::A_P2_DAT |=>
        wb_dat_o[7:0] == $past(p2_pin_i & ~p2_mode_r))
        else $error("port 2 read value wrong");
    AST_P3_DIR: assert property (@(posedge clk_i) disable iff (rst)
        wr && wb_adr_i == gp_pkg::A_P3_DIR |-> ##2
        p3_oe_o == ~$past(wb_dat_i[3:0], 2))
        else $error("port 3 direction not applied");
    AST_P4_PU: assert property (@(posedge clk_i) disable iff (rst)
        wr && wb_adr_i == gp_pkg::A_P4_PU |=>
        p4_pu_o == $past(wb_dat_i[3:0]))
        else $error("port 4 pull-up not applied");
    AST_EDGE: assert property (@(posedge clk_i) disable iff (rst)
        p12_mode_r && edge_rise_r[0] && $rose(p12_pin_i) |=> irq_st_r[0])
        else $error("rising edge not captured");
    AST_TMR_OUT: assert property (@(posedge clk_i) disable iff (rst)
        p3_mode_r[3] && $stable(p3_mode_r) |=>
        p3_out_o[3] == $past(timer_b_output_i))
        else $error("timer output not routed");
    AST_OPEN_DRAIN: assert property (@(posedge clk_i) disable iff (rst)
        ##1 p6_oe_o == $past(~p6_dir_r & ~p6_lat_r) && p6_out_o == 4'h0)
        else $error("port 6 drove high");
    AST_KEY: assert property (@(posedge clk_i) disable iff (rst)
        |(p7_mode_r & ~p7_pin_i & $past(p7_pin_i)) |=>
        irq_st_r[gp_pkg::KEY_BIT])
        else $error("key interrupt missed");
    AST_P13: assert property (@(posedge clk_i) disable iff (rst)
        wr && wb_adr_i == gp_pkg::A_P13_DAT |-> ##2
        p13_out_o == $past(wb_dat_i[0], 2))
        else $error("port 13 latch not driven");
    AST_BUZ: assert property (@(posedge clk_i) disable iff (rst)
        p14_mode_r[1] && $stable(p14_mode_r) |=>
        p14_out_o[1] == $past(buzzer_output_src_i))
        else $error("buzzer not routed");
    AST_RST: assert property (@(posedge clk_i) disable iff (rst_i)
        !sys_reset_n_i |=> p3_dir_r == 4'hf && !wb_ack_o && !irq_o)
        else $error("reset pin not honoured");
endmodule

/* testbench/gp_board_model.sv */
// board model: pin levels seen by the port block
`timescale 1ns/10ps
module gp_board_model #(
    parameter int W = 35
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] out_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] pu_i,
    input  wire logic [W-1:0] ext_i,
    input  wire logic [W-1:0] ext_en_i,
    output logic      [W-1:0] pin_o
);
    logic [W-1:0] flt_r = '0;
    always_ff @(posedge clk_i) begin
        flt_r <= ~flt_r;
    end
    // block drive first, then board, then pull-up, else a toggling float
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_i[i]) begin
                pin_o[i] = out_i[i];
            end else if (ext_en_i[i]) begin
                pin_o[i] = ext_i[i];
            end else begin
                pin_o[i] = pu_i[i] ? 1'b1 : flt_r[i];
            end
        end
    end
endmodule

/* testbench/mcu_port_pin_control_tb_top.sv */
// testbench: port block against the board model
`timescale 1ns/10ps
module mcu_port_pin_control_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        srst_n = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic        ack, irq, tclk, p13;
    logic        tmr = 1'b0;
    logic        clko = 1'b0;
    logic        buzo = 1'b0;
    logic [7:0]  ach;
    wire  [34:0] out, oe, pu, pin;
    logic [34:0] ext = '0;
    logic [34:0] ext_en = '1;
    int          err_total = 0;
    int          n_tests = 0;
    int          seed = 32'hf54c5058;
    logic [31:0] expq[$];

    always #5 clk_i = ~clk_i;
    assign out[7:0] = 8'h00;
    assign oe[7:0] = 8'h00;
    assign pu[7:0] = 8'h00;
    assign pu[23:20] = 4'h0;

    gp_port_ctrl i_gp_port_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .sys_reset_n_i(srst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .irq_o(irq), .p2_pin_i(pin[7:0]), .analog_input_channels_o(ach),
        .p3_pin_i(pin[11:8]), .p3_out_o(out[11:8]), .p3_oe_o(oe[11:8]),
        .p3_pu_o(pu[11:8]), .timer_b_output_i(tmr),
        .timer_b_count_clock_in_o(tclk),
        .p4_pin_i(pin[15:12]), .p4_out_o(out[15:12]), .p4_oe_o(oe[15:12]),
        .p4_pu_o(pu[15:12]), .p5_pin_i(pin[19:16]), .p5_out_o(out[19:16]),
        .p5_oe_o(oe[19:16]), .p5_pu_o(pu[19:16]), .p6_pin_i(pin[23:20]),
        .p6_out_o(out[23:20]), .p6_oe_o(oe[23:20]), .p7_pin_i(pin[31:24]),
        .p7_out_o(out[31:24]), .p7_oe_o(oe[31:24]), .p7_pu_o(pu[31:24]),
        .p12_pin_i(pin[32]), .p12_out_o(out[32]), .p12_oe_o(oe[32]),
        .p12_pu_o(pu[32]), .p13_out_o(p13), .p14_pin_i(pin[34:33]),
        .p14_out_o(out[34:33]), .p14_oe_o(oe[34:33]), .p14_pu_o(pu[34:33]),
        .clock_output_src_i(clko), .buzzer_output_src_i(buzo)
    );

    gp_board_model #(.W(35)) i_gp_board_model (
        .clk_i(clk_i), .out_i(out), .oe_i(oe), .pu_i(pu), .ext_i(ext),
        .ext_en_i(ext_en), .pin_o(pin)
    );

    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one classic cycle, held until ack, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            tally_and_finish();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk_i);
        #1;
        check(irq, e);
    endtask

    // read data compared with the oldest note
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
            check(dat_o, expq.pop_front());
        end
    end

    initial begin
        logic [7:0] ad[6];
        int         lsb[6];
        int         w[6];
        logic [7:0] d, l, p, m;
        ad = '{gp_pkg::A_P3_DAT, gp_pkg::A_P4_DAT, gp_pkg::A_P5_DAT,
               gp_pkg::A_P7_DAT, gp_pkg::A_P12_DAT, gp_pkg::A_P14_DAT};
        lsb = '{8, 12, 16, 24, 32, 33};
        w = '{4, 4, 4, 8, 1, 2};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        ext[7:0] <= 8'($random(seed));
        @(posedge clk_i);
        #1;
        check(oe, 35'h0);
        wb(1'b1, gp_pkg::A_P13_DAT, 32'h1);
        check(p13, 1'b1);
        @(posedge clk_i);
        srst_n <= 1'b0;
        @(posedge clk_i);
        srst_n <= 1'b1;
        @(posedge clk_i);
        #1;
        check(p13, 1'b0);
        wb(1'b1, gp_pkg::A_P2_MODE, 32'h0f);
        check(ach, 8'h0f);
        rd(gp_pkg::A_P2_DAT, {24'h0, ext[7:0] & 8'hf0});
        wb(1'b1, gp_pkg::A_IRQ_MSK, 32'h7f);
        wb(1'b1, gp_pkg::A_P12_MOD, 32'h1);
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, gp_pkg::A_EDGE_R, {31'h0, k != 1});
            wb(1'b1, gp_pkg::A_EDGE_F, {31'h0, k != 0});
            @(posedge clk_i);
            ext[32] <= 1'b1;
            irq_is(k != 1);
            rd(gp_pkg::A_IRQ_ST, {31'h0, k != 1});
            irq_is(1'b0);
            @(posedge clk_i);
            ext[32] <= 1'b0;
            irq_is(k != 0);
            rd(gp_pkg::A_IRQ_ST, {31'h0, k != 0});
        end
        @(posedge clk_i);
        ext[24] <= 1'b1;
        wb(1'b1, gp_pkg::A_IRQ_MSK, 32'h02);
        wb(1'b1, gp_pkg::A_P7_MODE, 32'h01);
        wb(1'b1, gp_pkg::A_P3_MODE, 32'h01);
        wb(1'b1, gp_pkg::A_EDGE_R, 32'h02);
        @(posedge clk_i);
        ext[24] <= 1'b0;
        irq_is(1'b0);
        @(posedge clk_i);
        ext[8] <= 1'b1;
        irq_is(1'b1);
        rd(gp_pkg::A_IRQ_ST, 32'h82);
        wb(1'b1, gp_pkg::A_P3_MODE, 32'h0);
        wb(1'b1, gp_pkg::A_P7_MODE, 32'h0);
        wb(1'b1, gp_pkg::A_P12_MOD, 32'h0);
        wb(1'b1, gp_pkg::A_P6_DIR, 32'h0);
        wb(1'b1, gp_pkg::A_P6_DAT, 32'h5);
        check(oe[23:20], 4'ha);
        check(out[23:20], 4'h0);
        rd(gp_pkg::A_P6_DAT, 32'h5);
        @(posedge clk_i);
        ext[34:8] <= 27'($random(seed));
        for (int i = 0; i < 6; i++) begin
            m = 8'((1 << w[i]) - 1);
            d = 8'($random(seed)) & m;
            l = 8'($random(seed));
            p = 8'($random(seed)) & m;
            wb(1'b1, ad[i] + 8'h04, {24'h0, d});
            wb(1'b1, ad[i] + 8'h08, {24'h0, p});
            wb(1'b1, ad[i], {24'h0, l});
            check(8'(oe >> lsb[i]) & m, ~d & m);
            check(8'(out >> lsb[i]) & ~d & m, l & ~d & m);
            check(8'(pu >> lsb[i]) & m, p);
            rd(ad[i], {24'h0, (8'(ext >> lsb[i]) & d) | (l & ~d & m)});
        end
        // alternate outputs: timer on port 3, clock and buzzer on port 14
        wb(1'b1, gp_pkg::A_P3_MODE, 32'h08);
        wb(1'b1, gp_pkg::A_P14_MOD, 32'h03);
        wb(1'b1, gp_pkg::A_P3_DIR, 32'h0);
        wb(1'b1, gp_pkg::A_P14_DIR, 32'h0);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            {tmr, clko, buzo} <= 3'($random(seed));
            repeat (2) @(posedge clk_i);
            #1;
            check(out[11], tmr);
            check(tclk, tmr);
            check(out[34:33], {buzo, clko});
        end
        wb(1'b1, gp_pkg::A_P5_DIR, 32'hff);
        wb(1'b1, gp_pkg::A_P5_PU, 32'h0f);
        @(posedge clk_i);
        ext_en[19:16] <= 4'h0;
        rd(gp_pkg::A_P5_DAT, 32'h0f);
        rd(8'h7c, 32'h0);
        tally_and_finish();
    end
endmodule
